// [bench/sram_dev_model.sv]
// Behavioural model of the asynchronous 4M x 16 static memory.
// Assumes the bench resolves the shared data lines from both drivers.
`timescale 1ns/1ns
`default_nettype none
module sram_dev_model (
  input  wire logic [21:0] addr,
  input  wire logic        sel_n,
  input  wire logic        sel,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        hi_n,
  input  wire logic        lo_n,
  input  wire logic [15:0] din,
  output logic      [15:0] dout,
  output logic      [1:0]  drive
);
  logic [15:0] mem [logic [21:0]];
  logic        act;
  logic        wr;
  logic [1:0]  lane_q;
  logic [21:0] adr_q;
  logic [15:0] dat_q;
  assign act = !sel_n && sel && !(hi_n && lo_n);
  assign wr = act && !we_n;
  assign drive = (act && we_n && !oe_n) ? {!hi_n, !lo_n} : 2'h0;
  always @* dout = mem.exists(addr) ? mem[addr] : 16'h0000;
  // Latched during the overlap so that any control may end the write.
  always @* if (wr) begin
    lane_q = {hi_n, lo_n};
    adr_q = addr;
    dat_q = din;
  end
  // The guard skips the spurious edge at time zero, before any write latched a lane.
  always @(negedge wr) begin
    if (lane_q != 2'h3) begin
      if (!mem.exists(adr_q)) mem[adr_q] = 16'h0000;
      if (!lane_q[0]) mem[adr_q][7:0] = dat_q[7:0];
      if (!lane_q[1]) mem[adr_q][15:8] = dat_q[15:8];
    end
  end
endmodule // sram_dev_model
`default_nettype wire

// [bench/sram_host_ctrl_checker.sv]
// Checker for the memory pins and user handshake of the static memory host controller.
// Assumes it is bound to sram_host_ctrl and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module sram_host_ctrl_checker #(
  parameter int ADDR_W = 22,
  parameter int DATA_W = 16
) (
  input wire logic              sys_clk,
  input wire logic              nrst,
  input wire logic              req_valid,
  input wire logic              req_write,
  input wire logic [1:0]        req_lane_n,
  input wire logic              req_ready,
  input wire logic              rsp_valid,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic              select_active_low,
  input wire logic              select_active_high,
  input wire logic              write_strobe_n,
  input wire logic              output_enable_n,
  input wire logic              upper_byte_lane_n,
  input wire logic              lower_byte_lane_n,
  input wire logic [DATA_W-1:0] data_lines_out,
  input wire logic [DATA_W-1:0] data_lines_oe_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  a_write_qualified: assert property ($fell(write_strobe_n) |-> !select_active_low &&
    select_active_high && !(upper_byte_lane_n && lower_byte_lane_n) && output_enable_n)
    else $error("strobe fell before all write controls were active");
  a_data_held: assert property ($rose(write_strobe_n) |->
    data_lines_oe_n == '0 && $stable(data_lines_out)) else $error("write data moved at strobe end");
  a_no_contention: assert property (!output_enable_n |-> data_lines_oe_n == '1)
    else $error("controller drives data while memory may drive");
  a_bus_turnaround: assert property ($fell(data_lines_oe_n[0]) |-> $past(output_enable_n))
    else $error("data driven without a turnaround cycle");
  a_idle_parked: assert property (select_active_low |->
    upper_byte_lane_n && lower_byte_lane_n && !select_active_high) else $error("idle pins not parked");
  a_read_controls: assert property (!output_enable_n |-> write_strobe_n &&
    !select_active_low && select_active_high) else $error("read controls wrong");
  a_addr_steady: assert property (!select_active_low && $past(!select_active_low) |->
    $stable(mem_addr)) else $error("address changed while selected");
  a_read_latency: assert property (req_valid && req_ready && !req_write &&
    req_lane_n != 2'h3 |=> !rsp_valid [*4] ##1 rsp_valid) else $error("read answer not in cycle 5");
  a_write_latency: assert property (req_valid && req_ready && req_write &&
    req_lane_n != 2'h3 |=> !rsp_valid [*3] ##1 rsp_valid) else $error("write answer not in cycle 4");
  a_strobe_pulse: assert property ($fell(write_strobe_n) |=> write_strobe_n ##1
    (select_active_low && data_lines_oe_n == '1)) else $error("write strobe pulse shape wrong");
endmodule // sram_host_ctrl_checker

bind sram_host_ctrl sram_host_ctrl_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (
  .sys_clk, .nrst, .req_valid, .req_write, .req_lane_n, .req_ready, .rsp_valid, .mem_addr,
  .select_active_low, .select_active_high, .write_strobe_n, .output_enable_n,
  .upper_byte_lane_n, .lower_byte_lane_n, .data_lines_out, .data_lines_oe_n);
`default_nettype wire

// [bench/sram_host_ctrl_tb.sv]
// Self-checking bench for the static memory host controller with a memory model.
// Assumes a 10 MHz clock and inputs changed 10 ns after each rising edge.
`timescale 1ns/1ns
`default_nettype none
module sram_host_ctrl_tb;
  logic        sys_clk = 1'b0;
  logic        nrst, req_valid, req_write, req_ready, rsp_valid;
  logic        sal, sah, we_n, oe_n, hi_n, lo_n;
  logic [21:0] req_addr, mem_addr;
  logic [1:0]  req_lane_n, drive;
  logic [15:0] req_wdata, rsp_rdata, d_out, d_oe_n, dout, bus, q;
  logic [15:0] flt = 16'hA5A5;
  int          bad_count = 0;
  int          num_checks = 0;
  int          cyc = 0;
  always #50 sys_clk = ~sys_clk;
  // Undriven lines toggle so a released bus never looks like held data.
  always @(posedge sys_clk) flt <= ~flt;
  assign bus = !d_oe_n[0] ? d_out : {drive[1] ? dout[15:8] : flt[15:8],
                                     drive[0] ? dout[7:0] : flt[7:0]};
  sram_host_ctrl uut (.sys_clk, .nrst, .req_valid, .req_write, .req_addr, .req_wdata,
    .req_lane_n, .req_ready, .rsp_valid, .rsp_rdata, .mem_addr, .select_active_low(sal),
    .select_active_high(sah), .write_strobe_n(we_n), .output_enable_n(oe_n),
    .upper_byte_lane_n(hi_n), .lower_byte_lane_n(lo_n), .data_lines_in(bus),
    .data_lines_out(d_out), .data_lines_oe_n(d_oe_n));
  sram_dev_model dev (.addr(mem_addr), .sel_n(sal), .sel(sah), .we_n, .oe_n, .hi_n, .lo_n,
    .din(bus), .dout, .drive);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic wr, input logic [21:0] a, input logic [15:0] d,
                      input logic [1:0] ln);
    int n;
    @(posedge sys_clk); #10;
    req_valid = 1'b1; req_write = wr; req_addr = a; req_wdata = d; req_lane_n = ln;
    @(posedge sys_clk); #10;
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 10) begin
      @(posedge sys_clk); #1;
      n++;
    end
    if (n == 10) begin
      bad_count++;
      $display("[FAIL] %0t no response", $time);
    end
    q = rsp_rdata;
  endtask
  task automatic t_reset;
    chk({10'h000, sal, sah, we_n, oe_n, hi_n, lo_n}, 16'h002F);
    chk(d_oe_n, 16'hFFFF);
    $display("test reset done");
  endtask
  task automatic t_full;
    xfer(1'b1, 22'h3FFFFF, 16'hA55A, 2'h0);
    xfer(1'b1, 22'h000000, 16'h1234, 2'h0);
    xfer(1'b0, 22'h3FFFFF, 16'h0000, 2'h0);
    chk(q, 16'hA55A);
    xfer(1'b0, 22'h000000, 16'h0000, 2'h0);
    chk(q, 16'h1234);
    $display("test full word done");
  endtask
  task automatic t_lanes;
    xfer(1'b1, 22'h000100, 16'hFFFF, 2'h0);
    xfer(1'b1, 22'h000100, 16'h1234, 2'h2);
    xfer(1'b1, 22'h000100, 16'hAB00, 2'h1);
    xfer(1'b0, 22'h000100, 16'h0000, 2'h0);
    chk(q, 16'hAB34);
    xfer(1'b0, 22'h000100, 16'h0000, 2'h2);
    chk(q, 16'h0034);
    xfer(1'b0, 22'h000100, 16'h0000, 2'h1);
    chk(q, 16'hAB00);
    $display("test byte lanes done");
  endtask
  task automatic t_drop;
    logic [15:0] seen;
    seen = 16'h0000;
    @(posedge sys_clk); #10;
    req_valid = 1'b1; req_write = 1'b1; req_addr = 22'h000100; req_lane_n = 2'h3;
    repeat (8) begin
      @(posedge sys_clk); #1;
      if (rsp_valid !== 1'b0 || sal !== 1'b1) seen++;
    end
    #9 req_valid = 1'b0;
    chk(seen, 16'h0000);
    xfer(1'b0, 22'h000100, 16'h0000, 2'h0);
    chk(q, 16'hAB34);
    $display("test no lane done");
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      $display("[FAIL] %0t timeout", $time);
      finish_test();
    end
  end
  initial begin
    nrst = 1'b0; req_valid = 1'b0; req_write = 1'b0;
    req_addr = 22'h000000; req_wdata = 16'h0000; req_lane_n = 2'h3;
    repeat (8) @(posedge sys_clk);
    #10 nrst = 1'b1;
    t_reset();
    t_full();
    t_lanes();
    t_drop();
    finish_test();
  end
endmodule // sram_host_ctrl_tb
`default_nettype wire

// [shared/sram_host_pkg.sv]
// Constants shared by the asynchronous static memory host controller.
// Assumes a 10 MHz system clock driving all controller logic.
`default_nettype none
package sram_host_pkg;

  localparam int  CLK_PERIOD_NS = 100;
  localparam int  ADDR_W        = 22;
  localparam int  DATA_W        = 16;
  localparam int  BYTE_W        = 8;

  // Access timing of the memory in nanoseconds.
  localparam int  READ_CYCLE_NS    = 55;
  localparam int  WRITE_PULSE_NS   = 45;
  localparam int  OUT_FLOAT_NS     = 20;
  localparam int  DATA_HOLD_NS     = 0;

  localparam int  READ_CYCLES  = (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int  WRITE_CYCLES = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int  FLOAT_CYCLES = (OUT_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int  HOLD_CYCLES  = (DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;

  localparam int  CNT_W = 4;

  localparam logic [1:0] BE_NONE = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_RSTRB = 3'h1,
    ST_RDONE = 3'h3,
    ST_TURN  = 3'h2,
    ST_WSTRB = 3'h6,
    ST_WHOLD = 3'h7
  } ctl_state_t;

endpackage
`default_nettype wire

// [src/sram_host_ctrl.sv]
// Host controller driving an asynchronous 4M x 16 static memory by its pins.
// Assumes one user request at a time on sys_clk and a memory without clock.
//
// What this block does
// - All qualifying controls are asserted before the write strobe goes active.
// - Write data stay stable around the strobe edge that ends the write.
// - Controller never drives data while the memory may still drive them.
// - Every select and lane enable is always held at a defined level.
// - Read keeps strobe high with selects, output enable and lanes asserted.
// - Address is valid no later than selects and lanes asserting.
`timescale 1ns/1ns
`default_nettype none
module sram_host_ctrl #(
  parameter int ADDR_W = sram_host_pkg::ADDR_W,
  parameter int DATA_W = sram_host_pkg::DATA_W
) (
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  // User request side.
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  input  wire logic [1:0]        req_lane_n,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic      [DATA_W-1:0] rsp_rdata,
  // Memory pins.
  output logic      [ADDR_W-1:0] mem_addr,
  output logic                   select_active_low,
  output logic                   select_active_high,
  output logic                   write_strobe_n,
  output logic                   output_enable_n,
  output logic                   upper_byte_lane_n,
  output logic                   lower_byte_lane_n,
  input  wire logic [DATA_W-1:0] data_lines_in,
  output logic      [DATA_W-1:0] data_lines_out,
  output logic      [DATA_W-1:0] data_lines_oe_n
);

  // Refused at elaboration: the split of the data word into two byte lanes assumes this geometry.
  if (ADDR_W != sram_host_pkg::ADDR_W || DATA_W != sram_host_pkg::DATA_W) begin : g_bad_size
    $error("sram_host_ctrl supports only the 22-bit by 16-bit memory");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data synchroniser.

  logic [DATA_W-1:0] rd_sync;

  sram_in_sync #(
    .WIDTH (DATA_W)
  ) u_rd_sync (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .async_in (data_lines_in),
    .sync_out (rd_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  sram_host_pkg::ctl_state_t state_ff, nxt_state;
  logic [sram_host_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [ADDR_W-1:0]               addr_ff, nxt_addr;
  logic [DATA_W-1:0]               wdata_ff, nxt_wdata;
  logic [1:0]                      lane_ff, nxt_lane;
  logic                            sel_ff, nxt_sel;
  logic                            oe_ff, nxt_oe;
  logic                            we_ff, nxt_we;
  logic                            drive_ff, nxt_drive;
  logic                            rsp_ff, nxt_rsp;
  logic [DATA_W-1:0]               rdata_ff, nxt_rdata;

  function automatic logic [sram_host_pkg::CNT_W-1:0] cycles(input int n);
    cycles = sram_host_pkg::CNT_W'(n);
  endfunction

  // Unread lanes take old_d, which the caller passes as zero, so the response shows only read bytes.
  function automatic logic [DATA_W-1:0] merge_lanes(input logic [DATA_W-1:0] old_d,
                                                    input logic [DATA_W-1:0] new_d,
                                                    input logic [1:0]        lane_n);
    logic [DATA_W-1:0] m;
    m = old_d;
    if (!lane_n[0]) begin
      m[sram_host_pkg::BYTE_W-1:0] = new_d[sram_host_pkg::BYTE_W-1:0];
    end
    if (!lane_n[1]) begin
      m[DATA_W-1:sram_host_pkg::BYTE_W] = new_d[DATA_W-1:sram_host_pkg::BYTE_W];
    end
    merge_lanes = m;
  endfunction

  assign req_ready = (state_ff == sram_host_pkg::ST_IDLE);

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_addr  = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_lane  = lane_ff;
    nxt_sel   = sel_ff;
    nxt_oe    = oe_ff;
    nxt_we    = we_ff;
    nxt_drive = drive_ff;
    nxt_rsp   = 1'b0;
    nxt_rdata = rdata_ff;
    case (state_ff)
      sram_host_pkg::ST_IDLE: begin
        // A request with no lane enabled would only deselect; it is ignored.
        if (req_valid && (req_lane_n != sram_host_pkg::BE_NONE)) begin
          nxt_addr  = req_addr;
          nxt_wdata = req_wdata;
          nxt_lane  = req_lane_n;
          nxt_sel   = 1'b1;
          if (req_write) begin
            nxt_oe    = 1'b0;
            nxt_cnt   = cycles(sram_host_pkg::FLOAT_CYCLES);
            nxt_state = sram_host_pkg::ST_TURN;
          end else begin
            nxt_oe    = 1'b1;
            nxt_cnt   = cycles(sram_host_pkg::READ_CYCLES + 2);
            nxt_state = sram_host_pkg::ST_RSTRB;
          end
        end
      end
      sram_host_pkg::ST_RSTRB: begin
        // Two extra cycles cover the read-back synchroniser latency.
        if (cnt_ff == cycles(1)) begin
          nxt_state = sram_host_pkg::ST_RDONE;
        end else begin
          nxt_cnt = cnt_ff - cycles(1);
        end
      end
      sram_host_pkg::ST_RDONE: begin
        nxt_rdata = merge_lanes('0, rd_sync, lane_ff);
        nxt_rsp   = 1'b1;
        nxt_sel   = 1'b0;
        nxt_oe    = 1'b0;
        nxt_lane  = sram_host_pkg::BE_NONE;
        nxt_state = sram_host_pkg::ST_IDLE;
      end
      sram_host_pkg::ST_TURN: begin
        // Output enable went high a cycle ago, so the memory has released the bus.
        if (cnt_ff <= cycles(1)) begin
          nxt_drive = 1'b1;
          nxt_we    = 1'b1;
          nxt_cnt   = cycles(sram_host_pkg::WRITE_CYCLES);
          nxt_state = sram_host_pkg::ST_WSTRB;
        end else begin
          nxt_cnt = cnt_ff - cycles(1);
        end
      end
      sram_host_pkg::ST_WSTRB: begin
        if (cnt_ff <= cycles(1)) begin
          nxt_we    = 1'b0;
          nxt_cnt   = cycles(sram_host_pkg::HOLD_CYCLES);
          nxt_state = sram_host_pkg::ST_WHOLD;
        end else begin
          nxt_cnt = cnt_ff - cycles(1);
        end
      end
      sram_host_pkg::ST_WHOLD: begin
        // Data and selects stay one cycle past the strobe edge that ends the write.
        if (cnt_ff <= cycles(1)) begin
          nxt_drive = 1'b0;
          nxt_sel   = 1'b0;
          nxt_lane  = sram_host_pkg::BE_NONE;
          nxt_rsp   = 1'b1;
          nxt_state = sram_host_pkg::ST_IDLE;
        end else begin
          nxt_cnt = cnt_ff - cycles(1);
        end
      end
      default: begin
        nxt_state = sram_host_pkg::ST_IDLE;
        nxt_sel   = 1'b0;
        nxt_oe    = 1'b0;
        nxt_we    = 1'b0;
        nxt_drive = 1'b0;
        nxt_lane  = sram_host_pkg::BE_NONE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= sram_host_pkg::ST_IDLE;
      cnt_ff   <= '0;
      addr_ff  <= '0;
      wdata_ff <= '0;
      lane_ff  <= sram_host_pkg::BE_NONE;
      sel_ff   <= 1'b0;
      oe_ff    <= 1'b0;
      we_ff    <= 1'b0;
      drive_ff <= 1'b0;
      rsp_ff   <= 1'b0;
      rdata_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      addr_ff  <= nxt_addr;
      wdata_ff <= nxt_wdata;
      lane_ff  <= nxt_lane;
      sel_ff   <= nxt_sel;
      oe_ff    <= nxt_oe;
      we_ff    <= nxt_we;
      drive_ff <= nxt_drive;
      rsp_ff   <= nxt_rsp;
      rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive: every control comes straight from a flop at a defined level.

  assign mem_addr           = addr_ff;
  assign select_active_low  = ~sel_ff;
  assign select_active_high = sel_ff;
  assign write_strobe_n     = ~we_ff;
  assign output_enable_n    = ~oe_ff;
  assign upper_byte_lane_n  = lane_ff[1];
  assign lower_byte_lane_n  = lane_ff[0];
  assign data_lines_out     = wdata_ff;
  assign data_lines_oe_n    = {DATA_W{~drive_ff}};
  assign rsp_valid          = rsp_ff;
  assign rsp_rdata          = rdata_ff;

endmodule // sram_host_ctrl
`default_nettype wire

// [src/sram_in_sync.sv]
// Two-flop synchroniser for the data lines read back from the memory.
// Assumes the memory data arrive asynchronously to sys_clk.
`timescale 1ns/1ns
`default_nettype none
module sram_in_sync #(
  parameter int WIDTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // Refused at elaboration so that a bad width never reaches simulation.
  if (WIDTH < 1) begin : g_bad_width
    $error("sram_in_sync WIDTH must be positive");
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule // sram_in_sync
`default_nettype wire
